/* design/jtlm_top.sv */
// Lane mapper, serializer power control and test pattern generator for a two-link transmitter
//
// Chosen here: strobed register access and the register offsets.
`timescale 1ns/1ps

module jtlm_top #(
	parameter int FRAME_DIV = 1,
	parameter int K_FRAMES = 32
) (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire jtlm_pkg::jtlm_bus_t i_bus,
	output logic [7:0] o_rd_data,
	input wire logic i_powerdown_pin,
	input wire logic i_sync_req_n,
	input wire logic [jtlm_pkg::LANES-1:0][jtlm_pkg::OCT_W-1:0] i_samples,
	output jtlm_pkg::jtlm_lanes_t o_lanes,
	output logic o_conv_off,
	output logic [1:0] o_chan_off
);
	// ****************************************
	// Parameter checks
	// ****************************************
	if (FRAME_DIV < 1 || FRAME_DIV > 255 || K_FRAMES < 2 || K_FRAMES > 256) begin : g_bad
		$error("jtlm_top: unsupported FRAME_DIV or K_FRAMES");
	end

	jtlm_pkg::jtlm_state_t s_q;
	jtlm_pkg::jtlm_state_t s_d;
	logic fen;
	logic pwr_ok;
	logic [3:0] act_lanes;
	logic dual;

	// Distinct nonzero seed per lane in the low seven bits
	function automatic logic [jtlm_pkg::PRBS_W-1:0] seed(input int l);
		seed = {16'hFFFF, 7'(l + 1)};
	endfunction

	// Eight pseudo-random bits, first generated bit lands in the MSB
	function automatic logic [jtlm_pkg::PRBS_W+7:0] prbs8(input logic [jtlm_pkg::PRBS_W-1:0] st,
		input logic [3:0] t);
		logic [7:0] o;
		logic nb;
		o = 8'h00;
		nb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			unique case (t)
				jtlm_pkg::TST_PRBS7: nb = st[jtlm_pkg::P7_A-1] ^ st[jtlm_pkg::P7_B-1];
				jtlm_pkg::TST_PRBS15: nb = st[jtlm_pkg::P15_A-1] ^ st[jtlm_pkg::P15_B-1];
				default: nb = st[jtlm_pkg::P23_A-1] ^ st[jtlm_pkg::P23_B-1];
			endcase
			o[7-i] = nb;
			st = {st[jtlm_pkg::PRBS_W-2:0], nb};
		end
		prbs8 = {st, o};
	endfunction

	// ****************************************
	// Decode of the frame enable, lane mode and power mode
	// ****************************************
	localparam logic [jtlm_pkg::CNT_W-1:0] CNT_MAX = jtlm_pkg::CNT_W'(FRAME_DIV - 1);
	localparam logic [jtlm_pkg::CNT_W-1:0] K_LAST = jtlm_pkg::CNT_W'(K_FRAMES - 1);

	// Frame enable pulse once per divider wrap
	assign fen = (s_q.div == CNT_MAX);

	// Active lane count per link and channel arrangement
	always_comb begin
		act_lanes = 4'h0;
		dual = 1'b0;
		unique case (s_q.lane_mode)
			jtlm_pkg::MODE_SC4: act_lanes = 4'h2;
			jtlm_pkg::MODE_SC8: act_lanes = 4'h4;
			jtlm_pkg::MODE_DC4: begin
				act_lanes = 4'h2;
				dual = 1'b1;
			end
			jtlm_pkg::MODE_DC8: begin
				act_lanes = 4'h4;
				dual = 1'b1;
			end
			jtlm_pkg::MODE_SC16: act_lanes = 4'h8;
			jtlm_pkg::MODE_DC16: begin
				act_lanes = 4'h8;
				dual = 1'b1;
			end
			default: act_lanes = 4'h0;
		endcase
	end

	assign pwr_ok = (s_q.pwr_mode == jtlm_pkg::PWR_NORM0) || (s_q.pwr_mode == jtlm_pkg::PWR_NORM1);

	// ****************************************
	// Next state
	// ****************************************
	always_comb begin
		logic [jtlm_pkg::PRBS_W+7:0] pr;
		logic [2:0] k;
		logic lk_b;
		logic act;
		logic [7:0] oct;
		logic ctl;
		pr = '0;
		k = 3'h0;
		lk_b = 1'b0;
		act = 1'b0;
		oct = 8'h00;
		ctl = 1'b0;
		s_d = s_q;

		// Register port, read data valid only the cycle after the strobe
		s_d.rdata = 8'h00;
		if (i_bus.rd) begin
			unique case (i_bus.addr)
				jtlm_pkg::REG_LANE_MODE: s_d.rdata = s_q.lane_mode;
				jtlm_pkg::REG_PWR_MODE: s_d.rdata = s_q.pwr_mode;
				jtlm_pkg::REG_CHAN_PD: s_d.rdata = {6'h00, s_q.chan_pd};
				jtlm_pkg::REG_KEEPALIVE: s_d.rdata = {6'h00, s_q.keep};
				jtlm_pkg::REG_TEST_SEL: s_d.rdata = {4'h0, s_q.test_sel};
				jtlm_pkg::REG_STATUS: s_d.rdata = {3'h0, s_q.chan_off, s_q.conv_off, s_q.lk};
				default: s_d.rdata = 8'h00;
			endcase
		end
		if (i_bus.wr) begin
			unique case (i_bus.addr)
				jtlm_pkg::REG_LANE_MODE: s_d.lane_mode = i_bus.wdata;
				jtlm_pkg::REG_PWR_MODE: s_d.pwr_mode = i_bus.wdata;
				jtlm_pkg::REG_CHAN_PD: s_d.chan_pd = i_bus.wdata[1:0];
				jtlm_pkg::REG_KEEPALIVE: s_d.keep = i_bus.wdata[1:0];
				jtlm_pkg::REG_TEST_SEL: s_d.test_sel = i_bus.wdata[3:0];
				default: s_d.rdata = s_d.rdata;
			endcase
		end

		// Frame enable divider
		s_d.div = fen ? '0 : s_q.div + 1'b1;

		s_d.conv_off = i_powerdown_pin | ~pwr_ok;
		s_d.chan_off = s_q.chan_pd | {2{i_powerdown_pin | ~pwr_ok}};

		// Link sequencing: sync, alignment, data
		if (fen) begin
			unique case (s_q.lk)
				jtlm_pkg::LK_SYNC: begin
					s_d.fcnt = '0;
					s_d.mcnt = 3'h0;
					if (i_sync_req_n) begin
						s_d.lk = jtlm_pkg::LK_ILAS;
					end
				end
				jtlm_pkg::LK_ILAS: begin
					s_d.fcnt = (s_q.fcnt == K_LAST) ? '0 : s_q.fcnt + 1'b1;
					if (s_q.fcnt == K_LAST) begin
						s_d.mcnt = s_q.mcnt + 3'h1;
						if (s_q.mcnt == 3'(jtlm_pkg::ILAS_MF - 1)) begin
							s_d.mcnt = 3'h0;
							if (s_q.test_sel != jtlm_pkg::TST_RILAS) begin
								s_d.lk = jtlm_pkg::LK_DATA;
							end
						end
					end
				end
				default: begin
					s_d.ramp = s_q.ramp + 8'h01;
					s_d.stpl_odd = ~s_q.stpl_odd;
				end
			endcase
			s_d.rpat_idx = (s_q.rpat_idx == 4'(jtlm_pkg::RPAT_LEN - 1)) ? 4'h0 : s_q.rpat_idx + 4'h1;
			if (!i_sync_req_n) begin
				s_d.lk = jtlm_pkg::LK_SYNC;
			end
		end

		// pseudo-random modes go raw to the serializer
		s_d.lanes.raw = (s_q.test_sel == jtlm_pkg::TST_PRBS7) || (s_q.test_sel == jtlm_pkg::TST_PRBS15)
			|| (s_q.test_sel == jtlm_pkg::TST_PRBS23);

		// Per-lane octet and power
		for (int l = 0; l < jtlm_pkg::LANES; l++) begin
			k = 3'(l % jtlm_pkg::LINK_LANES);
			lk_b = (l >= jtlm_pkg::LINK_LANES);
			act = ({1'b0, k} < act_lanes);
			pr = prbs8(s_q.prbs[l], s_q.test_sel);
			if (fen && s_d.lanes.raw) begin
				s_d.prbs[l] = pr[jtlm_pkg::PRBS_W+7:8];
			end
			oct = 8'h00;
			ctl = 1'b0;
			unique case (s_q.test_sel)
				jtlm_pkg::TST_PRBS7, jtlm_pkg::TST_PRBS15, jtlm_pkg::TST_PRBS23: oct = pr[7:0];
				jtlm_pkg::TST_D215: oct = jtlm_pkg::CHR_D21_5;
				jtlm_pkg::TST_K285: begin
					oct = jtlm_pkg::CHR_K28_5;
					ctl = 1'b1;
				end
				jtlm_pkg::TST_RPAT: oct = jtlm_pkg::RPAT[s_q.rpat_idx];
				default: begin
					if (s_q.lk == jtlm_pkg::LK_SYNC) begin
						oct = jtlm_pkg::CHR_K28_5;
						ctl = 1'b1;
					end else if (s_q.lk == jtlm_pkg::LK_ILAS) begin
						if (s_q.fcnt == '0) begin
							oct = jtlm_pkg::CHR_K28_0;
							ctl = 1'b1;
						end else if (s_q.fcnt == K_LAST) begin
							oct = jtlm_pkg::CHR_K28_3;
							ctl = 1'b1;
						end else begin
							oct = s_q.fcnt;
						end
					end else if (s_q.test_sel == jtlm_pkg::TST_RAMP) begin
						oct = s_q.ramp;
					end else if (s_q.test_sel == jtlm_pkg::TST_STPL) begin
						// lane k: k mod 4 then 0xFF minus k mod 4
						oct = s_q.stpl_odd ? jtlm_pkg::STPL_HI - 8'(k % jtlm_pkg::STPL_LANES)
							: jtlm_pkg::STPL_LO + 8'(k % jtlm_pkg::STPL_LANES);
					end else if (dual) begin
						// channel A on link A, channel B on link B
						oct = i_samples[{lk_b, k}];
					end else begin
						// even samples link A, odd samples link B
						// octet sent MSB first, no tail bits at eight bits
						oct = i_samples[{k, lk_b}];
					end
				end
			endcase
			if (!act) begin
				oct = jtlm_pkg::CHR_D21_5;
				ctl = 1'b0;
			end
			s_d.lanes.octet[l] = oct;
			s_d.lanes.ctrl[l] = ctl;
			// power follows lane mode, not test select
			s_d.lanes.pwr[l] = (act || s_q.keep[lk_b]) && !i_powerdown_pin && pwr_ok && !s_q.chan_pd[lk_b];
		end

		// test change or power-down restarts the link
		if ((i_bus.wr && i_bus.addr == jtlm_pkg::REG_TEST_SEL) || i_powerdown_pin || !pwr_ok) begin
			s_d.lk = jtlm_pkg::LK_SYNC;
		end

		if (!i_rst_n) begin
			s_d = '0;
			s_d.lane_mode = jtlm_pkg::LANE_MODE_RST;
			s_d.pwr_mode = jtlm_pkg::PWR_MODE_RST;
			s_d.test_sel = jtlm_pkg::TST_NORMAL;
			s_d.lk = jtlm_pkg::LK_SYNC;
			for (int l = 0; l < jtlm_pkg::LANES; l++) begin
				s_d.prbs[l] = seed(l);
			end
		end
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		s_q <= s_d;
	end

	// Outputs straight from the state register
	assign o_rd_data = s_q.rdata;
	assign o_lanes = s_q.lanes;
	assign o_conv_off = s_q.conv_off;
	assign o_chan_off = s_q.chan_off;

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);

	a_pin_lanes_off: assert property (i_powerdown_pin |=> (o_lanes.pwr == '0) && o_conv_off)
		else $error("lanes powered while pin high");
	a_bad_pwr_off: assert property (!pwr_ok |=> o_lanes.pwr == '0)
		else $error("lanes powered in bad power mode");
	a_chan_a_off: assert property (s_q.chan_pd[0] |=> o_lanes.pwr[7:0] == 8'h00 && o_chan_off[0])
		else $error("channel A lanes powered");
	a_keep_alive_on: assert property (s_q.keep[1] && pwr_ok && !i_powerdown_pin && !s_q.chan_pd[1]
		|=> o_lanes.pwr[15:8] == 8'hFF)
		else $error("keep-alive lanes not powered");
	a_sc8_map_ok: assert property (s_q.lane_mode == jtlm_pkg::MODE_SC8 && s_q.lk == jtlm_pkg::LK_DATA
		&& s_q.test_sel == jtlm_pkg::TST_NORMAL |=> o_lanes.octet[3] == $past(i_samples[6])
		&& o_lanes.octet[11] == $past(i_samples[7]))
		else $error("single-channel mapping wrong");
	a_dc16_map_ok: assert property (s_q.lane_mode == jtlm_pkg::MODE_DC16 && s_q.lk == jtlm_pkg::LK_DATA
		&& s_q.test_sel == jtlm_pkg::TST_NORMAL |=> o_lanes.octet[15] == $past(i_samples[15])
		&& o_lanes.octet[7] == $past(i_samples[7]))
		else $error("dual-channel mapping wrong");
	a_dc4_map_ok: assert property (s_q.lane_mode == jtlm_pkg::MODE_DC4 && s_q.lk == jtlm_pkg::LK_DATA
		&& s_q.test_sel == jtlm_pkg::TST_NORMAL |=> o_lanes.octet[1] == $past(i_samples[1])
		&& o_lanes.octet[9] == $past(i_samples[9]))
		else $error("dual-channel four-lane mapping wrong");
	a_dc8_map_ok: assert property (s_q.lane_mode == jtlm_pkg::MODE_DC8 && s_q.lk == jtlm_pkg::LK_DATA
		&& s_q.test_sel == jtlm_pkg::TST_NORMAL |=> o_lanes.octet[3] == $past(i_samples[3])
		&& o_lanes.octet[11] == $past(i_samples[11]))
		else $error("dual-channel eight-lane mapping wrong");
	a_sc16_map_ok: assert property (s_q.lane_mode == jtlm_pkg::MODE_SC16 && s_q.lk == jtlm_pkg::LK_DATA
		&& s_q.test_sel == jtlm_pkg::TST_NORMAL |=> o_lanes.octet[7] == $past(i_samples[14])
		&& o_lanes.octet[15] == $past(i_samples[15]))
		else $error("single-channel sixteen-lane mapping wrong");
	// Lane power tracks the lane mode when nothing else gates it
	a_pwr_follows_mode: assert property (pwr_ok && !i_powerdown_pin && s_q.chan_pd == 2'h0 && s_q.keep == 2'h0
		|=> o_lanes.pwr[0] == $past(act_lanes != 4'h0))
		else $error("lane power not following lane mode");
	a_prbs_raw_path: assert property (s_q.test_sel == jtlm_pkg::TST_PRBS7 |=> o_lanes.raw)
		else $error("prbs not bypassing encoder");
	// Lane 3 carries the highest short-pattern value pair
	a_stpl_lane3: assert property (s_q.test_sel == jtlm_pkg::TST_STPL && s_q.lk == jtlm_pkg::LK_DATA
		&& act_lanes > 4'h3 |=> o_lanes.octet[3] == ($past(s_q.stpl_odd) ? 8'hFC : 8'h03))
		else $error("short transport octet wrong");
	a_d215_stream: assert property (s_q.test_sel == jtlm_pkg::TST_D215 && act_lanes != 4'h0
		|=> o_lanes.octet[0] == jtlm_pkg::CHR_D21_5 && !o_lanes.ctrl[0])
		else $error("d21.5 stream broken");
	a_ramp_counts: assert property (fen && s_q.lk == jtlm_pkg::LK_DATA && s_q.test_sel == jtlm_pkg::TST_RAMP
		&& i_sync_req_n && !i_bus.wr ##1 s_q.test_sel == jtlm_pkg::TST_RAMP && s_q.lk == jtlm_pkg::LK_DATA
		|=> o_lanes.octet[0] == $past(o_lanes.octet[0]) + 8'h01)
		else $error("ramp did not step");
	a_k285_stream: assert property (s_q.test_sel == jtlm_pkg::TST_K285 && act_lanes != 4'h0
		|=> o_lanes.octet[0] == jtlm_pkg::CHR_K28_5 && o_lanes.ctrl[0])
		else $error("k28.5 stream broken");
	a_rilas_no_data: assert property (s_q.test_sel == jtlm_pkg::TST_RILAS && s_q.lk != jtlm_pkg::LK_DATA
		&& !i_bus.wr |=> s_q.lk != jtlm_pkg::LK_DATA)
		else $error("data phase entered in repeated alignment");
	a_rpat_octet: assert property (s_q.test_sel == jtlm_pkg::TST_RPAT && act_lanes != 4'h0
		|=> o_lanes.octet[0] == jtlm_pkg::RPAT[$past(s_q.rpat_idx)])
		else $error("rpat octet wrong");

	c_data_phase: cover property (s_q.lk == jtlm_pkg::LK_ILAS ##1 s_q.lk == jtlm_pkg::LK_DATA);
	c_stpl_frame: cover property (s_q.test_sel == jtlm_pkg::TST_STPL && s_q.lk == jtlm_pkg::LK_DATA);
	c_prbs_run: cover property (s_q.test_sel == jtlm_pkg::TST_PRBS23 && o_lanes.raw);
	c_pin_down: cover property (i_powerdown_pin ##1 !i_powerdown_pin);
endmodule

/* design/jtlm_pkg.sv */
// Constants, carriers and state type for the transmit lane mapper and pattern generator
package jtlm_pkg;
	// ****************************************
	// Geometry
	// ****************************************
	localparam int LANES = 16;
	localparam int LINK_LANES = 8;
	localparam int OCT_W = 8;
	localparam int ADDR_W = 8;
	localparam int PRBS_W = 23;
	localparam int CNT_W = 8;

	// ****************************************
	// Register offsets and reset values
	// ****************************************
	localparam logic [7:0] REG_LANE_MODE = 8'h00;
	localparam logic [7:0] REG_PWR_MODE = 8'h04;
	localparam logic [7:0] REG_CHAN_PD = 8'h08;
	localparam logic [7:0] REG_KEEPALIVE = 8'h0C;
	localparam logic [7:0] REG_TEST_SEL = 8'h10;
	localparam logic [7:0] REG_STATUS = 8'h14;
	localparam logic [7:0] LANE_MODE_RST = 8'h05;
	localparam logic [7:0] PWR_MODE_RST = 8'h00;

	// ****************************************
	// Lane modes and power modes
	// ****************************************
	localparam logic [7:0] MODE_SC4 = 8'h04;
	localparam logic [7:0] MODE_SC8 = 8'h05;
	localparam logic [7:0] MODE_DC4 = 8'h06;
	localparam logic [7:0] MODE_DC8 = 8'h07;
	localparam logic [7:0] MODE_SC16 = 8'h11;
	localparam logic [7:0] MODE_DC16 = 8'h12;
	localparam logic [7:0] PWR_NORM0 = 8'h00;
	localparam logic [7:0] PWR_NORM1 = 8'h01;

	// ****************************************
	// Test select codes
	// ****************************************
	localparam logic [3:0] TST_NORMAL = 4'h0;
	localparam logic [3:0] TST_PRBS7 = 4'h1;
	localparam logic [3:0] TST_PRBS15 = 4'h2;
	localparam logic [3:0] TST_PRBS23 = 4'h3;
	localparam logic [3:0] TST_RAMP = 4'h4;
	localparam logic [3:0] TST_STPL = 4'h5;
	localparam logic [3:0] TST_D215 = 4'h6;
	localparam logic [3:0] TST_K285 = 4'h7;
	localparam logic [3:0] TST_RILAS = 4'h8;
	localparam logic [3:0] TST_RPAT = 4'h9;

	// ****************************************
	// Characters and patterns
	// ****************************************
	localparam logic [7:0] CHR_K28_5 = 8'hBC;
	localparam logic [7:0] CHR_D21_5 = 8'hB5;
	localparam logic [7:0] CHR_K28_0 = 8'h1C;
	localparam logic [7:0] CHR_K28_3 = 8'h7C;
	localparam logic [7:0] STPL_LO = 8'h00;
	localparam logic [7:0] STPL_HI = 8'hFF;
	localparam int STPL_LANES = 4;
	localparam int ILAS_MF = 4;
	localparam int RPAT_LEN = 12;
	localparam logic [7:0] RPAT [RPAT_LEN] = '{8'hBE, 8'hD7, 8'h23, 8'h47, 8'h6B, 8'h8F,
		8'hB3, 8'h14, 8'h5E, 8'hFB, 8'h35, 8'h59};
	localparam int P7_A = 6;
	localparam int P7_B = 7;
	localparam int P15_A = 14;
	localparam int P15_B = 15;
	localparam int P23_A = 18;
	localparam int P23_B = 23;

	// ****************************************
	// Carriers and state
	// ****************************************
	typedef enum logic [1:0] {LK_SYNC, LK_ILAS, LK_DATA} jtlm_link_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} jtlm_bus_t;

	typedef struct packed {
		logic [LANES-1:0][OCT_W-1:0] octet;
		logic [LANES-1:0] ctrl;
		logic [LANES-1:0] pwr;
		logic raw;
	} jtlm_lanes_t;

	typedef struct packed {
		logic [7:0] lane_mode;
		logic [7:0] pwr_mode;
		logic [1:0] chan_pd;
		logic [1:0] keep;
		logic [3:0] test_sel;
		logic [7:0] rdata;
		jtlm_link_t lk;
		logic [CNT_W-1:0] div;
		logic [CNT_W-1:0] fcnt;
		logic [2:0] mcnt;
		logic [7:0] ramp;
		logic stpl_odd;
		logic [3:0] rpat_idx;
		logic [LANES-1:0][PRBS_W-1:0] prbs;
		jtlm_lanes_t lanes;
		logic conv_off;
		logic [1:0] chan_off;
	} jtlm_state_t;
endpackage

/* test/jtlm_rx_model.sv */
// Far-end receiver model that requests and releases link sync
`timescale 1ns/1ps

module jtlm_rx_model (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire jtlm_pkg::jtlm_lanes_t i_lanes,
	input wire logic i_link_off,
	input wire logic [3:0] i_lock_need,
	output logic o_sync_req_n
);
	logic [3:0] k_cnt_q;

	// relock after power loss
	// Count K28.5 frames on lane 0; a dark lane or disabled link restarts lock
	always_ff @(posedge i_ref_clk) begin
		if (!i_rst_n || i_link_off || !i_lanes.pwr[0]) begin
			k_cnt_q <= 4'h0;
			o_sync_req_n <= 1'b0;
		end else if (i_lanes.ctrl[0] && i_lanes.octet[0] == jtlm_pkg::CHR_K28_5) begin
			if (k_cnt_q >= i_lock_need) begin
				o_sync_req_n <= 1'b1;
			end else begin
				k_cnt_q <= k_cnt_q + 4'h1;
			end
		end
	end
endmodule

/* test/tb_top.sv */
// Self-checking bench for lane mapping, power control and test patterns
`timescale 1ns/1ps

module tb_top;
	// ********
	// Signals
	// ********
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	jtlm_pkg::jtlm_bus_t i_bus = '0;
	logic i_powerdown_pin = 1'b0;
	logic [15:0][7:0] i_samples = '0;
	logic link_off = 1'b0;
	logic [3:0] lock_need = 4'h2;
	logic sync_n;
	logic [7:0] o_rd_data;
	jtlm_pkg::jtlm_lanes_t o_lanes;
	logic o_conv_off;
	logic [1:0] o_chan_off;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	logic [7:0] q0[$];
	logic [7:0] q1[$];
	logic [7:0] rd;
	logic [7:0] modes[6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h11, 8'h12};

	// Clock, 5 ns period
	always #2.5 i_ref_clk = ~i_ref_clk;

	jtlm_top #(.FRAME_DIV(1), .K_FRAMES(4)) u_jtlm_top (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_bus(i_bus),
		.o_rd_data(o_rd_data),
		.i_powerdown_pin(i_powerdown_pin),
		.i_sync_req_n(sync_n),
		.i_samples(i_samples),
		.o_lanes(o_lanes),
		.o_conv_off(o_conv_off),
		.o_chan_off(o_chan_off)
	);

	jtlm_rx_model u_jtlm_rx_model (
		.i_ref_clk(i_ref_clk),
		.i_rst_n(i_rst_n),
		.i_lanes(o_lanes),
		.i_link_off(link_off),
		.i_lock_need(lock_need),
		.o_sync_req_n(sync_n)
	);

	// ********
	// Helpers
	// ********
	task automatic report_and_stop();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	task automatic chk_oct(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: octet %h not %h", $time, got, exp);
		end
	endtask

	task automatic chk_vec(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value at %0t: flags %h not %h", $time, got, exp);
		end
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_ref_clk);
		i_bus <= '0;
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge i_ref_clk);
		i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_ref_clk);
		i_bus <= '0;
		#1;
		d = o_rd_data;
	endtask

	task automatic settle();
		repeat (2) @(posedge i_ref_clk);
		#1;
	endtask

	// Poll status until the link reports data phase
	task automatic wait_data();
		int n;
		n = 0;
		rd = 8'h00;
		while (rd[1:0] !== 2'h2 && n < 200) begin
			bus_rd(jtlm_pkg::REG_STATUS, rd);
			n++;
		end
		chk_vec(16'(rd[1:0]), 16'h0002);
	endtask

	// Active lanes per link for a lane mode
	function automatic int act(input logic [7:0] m);
		case (m)
			8'h04, 8'h06: return 2;
			8'h05, 8'h07: return 4;
			8'h11, 8'h12: return 8;
			default: return 0;
		endcase
	endfunction

	// Expected lane octet: even/odd split for single channel, per channel for dual
	function automatic logic [7:0] exp_oct(input logic [7:0] m, input int i, input logic [15:0][7:0] s);
		if (i % 8 >= act(m)) return 8'hB5;
		if (m == 8'h04 || m == 8'h05 || m == 8'h11) return s[2 * (i % 8) + i / 8];
		return s[i];
	endfunction

	// Serial bit n of lane 0, most significant bit first
	function automatic logic bit_at(input int n);
		return q0[n / 8][7 - n % 8];
	endfunction

	// Hang guard
	always @(posedge i_ref_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			report_and_stop();
		end
	end

	// ********
	// Main sequence
	// ********
	initial begin
		int c;
		int p;
		int pa;
		int pb;
		logic [15:0] pw;
		void'($urandom(11368));
		repeat (16) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		bus_rd(jtlm_pkg::REG_LANE_MODE, rd);
		chk_oct(rd, 8'h05);
		bus_rd(jtlm_pkg::REG_PWR_MODE, rd);
		chk_oct(rd, 8'h00);
		bus_rd(jtlm_pkg::REG_TEST_SEL, rd);
		chk_oct(rd, 8'h00);
		bus_rd(8'hFC, rd);
		chk_oct(rd, 8'h00);
		wait_data();
		// Sample mapping in every lane mode
		foreach (modes[mi]) begin
			bus_wr(jtlm_pkg::REG_LANE_MODE, modes[mi]);
			repeat (6) begin
				@(posedge i_ref_clk);
				i_samples <= {$urandom, $urandom, $urandom, $urandom};
				@(posedge i_ref_clk);
				#1;
				for (int i = 0; i < 16; i++) begin
					chk_oct(o_lanes.octet[i], exp_oct(modes[mi], i, i_samples));
					pw[i] = (i % 8) < act(modes[mi]);
				end
				chk_vec(o_lanes.pwr, pw);
			end
		end
		// Keep-alive, channel and converter power control
		bus_wr(jtlm_pkg::REG_LANE_MODE, 8'h05);
		bus_wr(jtlm_pkg::REG_KEEPALIVE, 8'h03);
		settle();
		chk_vec(o_lanes.pwr, 16'hFFFF);
		chk_oct(o_lanes.octet[15], 8'hB5);
		bus_wr(jtlm_pkg::REG_KEEPALIVE, 8'h00);
		for (int k = 1; k < 3; k++) begin
			bus_wr(jtlm_pkg::REG_CHAN_PD, 8'(k));
			settle();
			chk_vec(16'(o_chan_off), 16'(k));
			chk_vec(o_lanes.pwr, k == 1 ? 16'h0F00 : 16'h000F);
		end
		bus_wr(jtlm_pkg::REG_CHAN_PD, 8'h00);
		bus_wr(jtlm_pkg::REG_PWR_MODE, 8'($urandom_range(2, 255)));
		settle();
		chk_vec({o_lanes.pwr[14:0], o_conv_off}, 16'h0001);
		bus_wr(jtlm_pkg::REG_PWR_MODE, 8'h01);
		settle();
		chk_vec({o_lanes.pwr[14:0], o_conv_off}, 16'h1E1E);
		@(posedge i_ref_clk);
		i_powerdown_pin <= 1'b1;
		settle();
		chk_vec({o_lanes.pwr[14:0], o_conv_off}, 16'h0001);
		@(posedge i_ref_clk);
		i_powerdown_pin <= 1'b0;
		wait_data();
		// Every test pattern, link disabled around each selection
		for (int t = 1; t < 10; t++) begin
			@(posedge i_ref_clk);
			link_off <= 1'b1;
			lock_need <= 4'($urandom_range(1, 8));
			bus_wr(jtlm_pkg::REG_TEST_SEL, 8'(t));
			link_off <= 1'b0;
			q0.delete();
			q1.delete();
			repeat (64) begin
				@(posedge i_ref_clk);
				#1;
				q0.push_back(o_lanes.octet[0]);
				q1.push_back(o_lanes.octet[9]);
				chk_vec(o_lanes.pwr, 16'h0F0F);
				chk_vec(16'(o_lanes.raw), 16'(t < 4));
				if (t == 6 || t == 7) begin
					chk_oct(o_lanes.octet[9], t == 6 ? 8'hB5 : 8'hBC);
					chk_vec(16'(o_lanes.ctrl[9]), 16'(t == 7));
				end
			end
			case (t)
				1, 2, 3: begin
					pa = t == 1 ? 6 : t == 2 ? 14 : 18;
					pb = t == 1 ? 7 : t == 2 ? 15 : 23;
					for (int n = pb; n < 512; n++) begin
						chk_vec(16'(bit_at(n)), 16'(bit_at(n - pa) ^ bit_at(n - pb)));
					end
					chk_vec(16'(q0[5] == q1[5] && q0[6] == q1[6]), 16'h0000);
				end
				4, 5: begin
					for (int i = 40; i < 64; i++) begin
						chk_oct(q0[i], t == 4 ? q0[i - 1] + 8'h01 : ~q0[i - 1]);
						chk_oct(q1[i], t == 4 ? q0[i] : q0[i] ^ 8'h01);
					end
				end
				8: begin
					c = 0;
					foreach (q0[i]) begin
						c += (q0[i] == 8'h1C);
					end
					chk_vec(16'(c >= 2), 16'h0001);
					bus_rd(jtlm_pkg::REG_STATUS, rd);
					chk_vec(16'(rd[1:0]), 16'h0001);
				end
				9: begin
					p = 0;
					for (int j = 0; j < 12; j++) begin
						if (jtlm_pkg::RPAT[j] == q0[0]) p = j;
					end
					foreach (q0[i]) begin
						chk_oct(q0[i], jtlm_pkg::RPAT[(p + i) % 12]);
					end
				end
				default: ;
			endcase
		end
		bus_wr(jtlm_pkg::REG_TEST_SEL, 8'h00);
		report_and_stop();
	end
endmodule
